// file: logic/sdc_ctrl.sv
/*
 SDRAM controller command and configuration logic with APB registers.
 Assumes acc_req held until acc_ack, same clock; memory on SDR pins.
*/
`timescale 1ns/1ps
module sdc_ctrl
  import sdc_pkg::*;
#(
  parameter logic [31:0] MEM_BASE = 32'h20000000
)(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Memory access request
  input  wire logic        acc_req,
  input  wire logic        acc_wr,
  input  wire logic [31:0] acc_addr,
  output logic             acc_ack,
  // Memory device pins
  output logic             mem_cs_n,
  output logic             mem_ras_n,
  output logic             mem_cas_n,
  output logic             mem_we_n,
  output logic [12:0]      mem_addr,
  output logic [1:0]       mem_ba,
  output logic             memory_clock_enable,
  output logic             memory_clock_out
);
  logic [2:0]  mode_r;
  logic [11:0] ref_cnt_r;
  logic [31:0] geom_r;
  logic [31:0] lpr_r;
  logic        rerr_r;
  logic        ref_written_r;
  logic        ref_pend_r;
  logic        ref_tick;
  logic        ref_done_r;
  logic [31:0] rdata_nxt;
  logic        hit;
  logic        wr_en;
  logic        rd_status;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;
  sdc_state_t  st_r;
  logic [3:0]  cmd_r;
  logic [12:0] addr_r;
  logic [1:0]  ba_r;
  logic        cke_r;
  logic        clk_out_r;
  logic        tick_r;
  logic        sref_r;
  logic        busy_r;
  logic        is_wr_r;
  logic        ack_r;
  logic [3:0]  cnt_r;
  logic [3:0]  ras_r;
  logic [7:0]  idle_r;
  logic [7:0]  tmo;
  logic [1:0]  lp_sel;
  logic [31:0] acc_off;
  sdc_loc_t    loc;
  logic        step;

  assign lp_sel  = lpr_r[FLD_LOW_POWER_SELECT +: 2];
  assign acc_off = acc_addr - MEM_BASE; // [R2]
  assign loc     = sdc_split(acc_off, geom_r);
  assign step    = tick_r;

  // APB decode
  always_comb begin
    hit       = 1'b1;
    rdata_nxt = 32'h00000000;
    if (paddr == OFS_CMD_MODE) begin
      rdata_nxt = {29'h0, mode_r};
    end else if (paddr == OFS_REF_INT) begin
      rdata_nxt = {20'h0, ref_cnt_r};
    end else if (paddr == OFS_GEOM) begin
      rdata_nxt = geom_r;
    end else if (paddr == OFS_LOW_PWR) begin
      rdata_nxt = lpr_r;
    end else if (paddr == OFS_STATUS) begin
      rdata_nxt = {31'h0, rerr_r};
    end else begin
      hit = 1'b0;
    end
  end

  assign wr_en     = psel && penable && pready_r && pwrite && hit;
  assign rd_status = psel && penable && pready_r && !pwrite &&
                     paddr == OFS_STATUS;

  // One wait-free access phase per transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end else begin
      pready_r  <= psel && !penable;
      pslverr_r <= psel && !penable && !hit;
      if (psel && !penable) begin
        prdata_r <= rdata_nxt;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r        <= 3'h0;
      ref_cnt_r     <= 12'h000;
      geom_r        <= RST_GEOM; // [R8] [R9] [R10] [R11]
      lpr_r         <= 32'h00000000;
      ref_written_r <= 1'b0;
    end else if (wr_en) begin
      if (paddr == OFS_CMD_MODE) begin
        mode_r <= pwdata[2:0] & MSK_MODE[2:0];
      end else if (paddr == OFS_REF_INT) begin
        ref_cnt_r     <= pwdata[11:0] & MSK_REF[11:0];
        ref_written_r <= 1'b1; // [R7]
      end else if (paddr == OFS_GEOM) begin
        geom_r <= pwdata; // [R12] [R13] [R14] [R15] [R16] [R17]
      end else if (paddr == OFS_LOW_PWR) begin
        lpr_r <= pwdata & MSK_LPR; // [R22]
      end
    end
  end

  sdc_ref_timer u_ref_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (wr_en && paddr == OFS_REF_INT),
    .count   ((wr_en && paddr == OFS_REF_INT) ? pwdata[11:0] : ref_cnt_r),
    .tick_r  (ref_tick)
  );

  // Pending refresh and missed-refresh error, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_pend_r <= 1'b0;
      rerr_r     <= 1'b0;
    end else begin
      if (ref_tick) begin
        ref_pend_r <= 1'b1; // [R6]
      end else if (ref_done_r || st_r == ST_DPD ||
                   (st_r == ST_LP && sref_r)) begin
        ref_pend_r <= 1'b0;
      end
      if (ref_tick && ref_pend_r) begin
        rerr_r <= 1'b1; // [R24]
      end else if (rd_status) begin
        rerr_r <= 1'b0; // [R24]
      end
    end
  end

  // Low-power entry timeout in master clock cycles
  always_comb begin
    case (lpr_r[FLD_TMO +: 2])
      2'h1:    tmo = TMO_64; // [R23]
      2'h2:    tmo = TMO_128; // [R23]
      default: tmo = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_r <= 8'h00;
    end else if (st_r != ST_IDLE || acc_req) begin
      idle_r <= 8'h00;
    end else if (idle_r != TMO_128) begin
      idle_r <= idle_r + 8'h01;
    end
  end

  // Memory clock: each command stands for one full memory clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_r    <= 1'b0;
      clk_out_r <= 1'b0;
    end else begin
      tick_r    <= !tick_r;
      clk_out_r <= !tick_r && !(st_r == ST_LP && sref_r); // [R19]
    end
  end

  // Command sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r       <= ST_IDLE;
      cmd_r      <= CMD_NOP;
      addr_r     <= 13'h0000;
      ba_r       <= 2'h0;
      cke_r      <= 1'b1;
      cnt_r      <= 4'h0;
      ras_r      <= 4'h0;
      sref_r     <= 1'b0;
      busy_r     <= 1'b0;
      is_wr_r    <= 1'b0;
      ack_r      <= 1'b0;
      ref_done_r <= 1'b0;
    end else begin
      ack_r      <= 1'b0;
      ref_done_r <= 1'b0;
      if (step) begin
        cmd_r <= CMD_NOP;
        if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
        if (ras_r != 4'h0) ras_r <= ras_r - 4'h1;
        case (st_r)
          ST_IDLE: begin
            if (ref_pend_r) begin
              cmd_r      <= CMD_AREF; // [R6]
              cnt_r      <= geom_r[FLD_TRC +: 4]; // [R13]
              ref_done_r <= 1'b1;
              st_r       <= ST_REF_WAIT;
            end else if (acc_req) begin
              busy_r  <= 1'b1;
              is_wr_r <= acc_wr;
              case (mode_r)
                MODE_NOP: begin
                  st_r <= ST_ACK; // [R1]
                end
                MODE_PALL: begin
                  cmd_r         <= CMD_PRE; // [R1]
                  addr_r        <= 13'h0000;
                  addr_r[A_ALL] <= 1'b1;
                  cnt_r         <= geom_r[FLD_TRP +: 4]; // [R14]
                  st_r          <= ST_PRE_WAIT;
                end
                MODE_LMR: begin
                  cmd_r  <= CMD_LMR; // [R2]
                  addr_r <= acc_off[12:0]; // [R2]
                  ba_r   <= acc_off[14:13];
                  st_r   <= ST_ACK;
                end
                MODE_AREF: begin
                  cmd_r <= CMD_AREF; // [R4]
                  cnt_r <= geom_r[FLD_TRC +: 4]; // [R13]
                  st_r  <= ST_REF_WAIT;
                end
                MODE_EMR: begin
                  cmd_r  <= CMD_LMR; // [R3]
                  addr_r <= acc_off[12:0]; // [R3]
                  ba_r   <= BA_EXT;
                  st_r   <= ST_ACK;
                end
                MODE_DPD: begin
                  cmd_r <= CMD_BST; // [R5]
                  cke_r <= 1'b0; // [R5]
                  st_r  <= ST_DPD;
                  ack_r <= 1'b1;
                  busy_r <= 1'b0;
                end
                default: begin
                  cmd_r  <= CMD_ACT; // [R1] [R25]
                  addr_r <= loc.row;
                  ba_r   <= loc.ba;
                  cnt_r  <= geom_r[FLD_ROW_TO_COLUMN_CYCLES +: 4]; // [R15]
                  ras_r  <= geom_r[FLD_ACTIVE_TO_PRECHARGE_CYCLES +: 4]; // [R16]
                  st_r   <= ST_ACT_WAIT;
                end
              endcase
            end else if (lp_sel != LP_OFF && idle_r >= tmo) begin
              cke_r  <= 1'b0; // [R18] [R20]
              sref_r <= lp_sel == LP_SREF;
              if (lp_sel == LP_SREF) begin
                cmd_r <= CMD_AREF; // [R19]
                st_r  <= ST_LP;
              end else if (lp_sel == LP_DEEP) begin
                cmd_r <= CMD_BST; // [R21]
                st_r  <= ST_DPD;
              end else begin
                st_r <= ST_LP; // [R20]
              end
            end
          end
          ST_ACT_WAIT: begin
            if (cnt_r == 4'h0) begin
              cmd_r  <= is_wr_r ? CMD_WR : CMD_RD; // [R15]
              addr_r <= loc.col;
              cnt_r  <= is_wr_r ? geom_r[FLD_TWR +: 4] // [R12]
                                : {2'h0, geom_r[FLD_CAS +: 2]}; // [R10]
              st_r   <= ST_POST;
            end
          end
          ST_POST: begin
            if (cnt_r == 4'h0 && ras_r == 4'h0) begin
              cmd_r         <= CMD_PRE; // [R16]
              addr_r[A_ALL] <= 1'b1;
              cnt_r         <= geom_r[FLD_TRP +: 4]; // [R14]
              st_r          <= ST_PRE_WAIT;
            end
          end
          ST_PRE_WAIT: begin
            if (cnt_r == 4'h0) st_r <= ST_ACK; // [R14]
          end
          ST_REF_WAIT: begin
            if (cnt_r == 4'h0) st_r <= busy_r ? ST_ACK : ST_IDLE; // [R13]
          end
          ST_LP: begin
            if (acc_req || lp_sel == LP_OFF ||
                (ref_pend_r && !sref_r)) begin
              cke_r  <= 1'b1; // [R19] [R20]
              cnt_r  <= sref_r ? geom_r[FLD_SELF_REFRESH_EXIT_CYCLES +: 4] : 4'h0; // [R17]
              sref_r <= 1'b0;
              st_r   <= ST_EXIT_WAIT;
            end
          end
          ST_DPD: begin
            if (acc_req && mode_r != MODE_DPD) begin
              cke_r <= 1'b1;
              cnt_r <= geom_r[FLD_SELF_REFRESH_EXIT_CYCLES +: 4]; // [R17]
              st_r  <= ST_EXIT_WAIT;
            end
          end
          ST_EXIT_WAIT: begin
            if (cnt_r == 4'h0) st_r <= ST_IDLE; // [R17]
          end
          ST_ACK: begin
            ack_r  <= 1'b1;
            busy_r <= 1'b0;
            st_r   <= ST_IDLE;
          end
          default: st_r <= ST_IDLE;
        endcase
      end
    end
  end

  assign prdata              = prdata_r;
  assign pready              = pready_r;
  assign pslverr             = pslverr_r;
  assign acc_ack             = ack_r;
  assign {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} = cmd_r;
  assign mem_addr            = addr_r;
  assign mem_ba              = ba_r;
  assign memory_clock_enable = cke_r;
  assign memory_clock_out    = clk_out_r;

  // Checks
  logic take;
  assign take = step && st_r == ST_IDLE && acc_req && !ref_pend_r;

  property p_nop_mode;
    @(posedge pclk) disable iff (!presetn)
      take && mode_r == MODE_NOP |=> cmd_r == CMD_NOP ##2 ack_r;
  endproperty
  a_nop_mode: assert property (p_nop_mode) // [R1]
    else $error("NOP mode did not answer with NOP");

  property p_prea_mode;
    @(posedge pclk) disable iff (!presetn)
      take && mode_r == MODE_PALL |=> cmd_r == CMD_PRE && addr_r[A_ALL];
  endproperty
  a_prea_mode: assert property (p_prea_mode) // [R1]
    else $error("precharge-all mode wrong command");

  property p_lmr_mode;
    @(posedge pclk) disable iff (!presetn)
      take && mode_r == MODE_LMR |=>
        cmd_r == CMD_LMR && addr_r == $past(acc_off[12:0]);
  endproperty
  a_lmr_mode: assert property (p_lmr_mode) // [R2]
    else $error("load mode value not the offset");

  property p_emr_mode;
    @(posedge pclk) disable iff (!presetn)
      take && mode_r == MODE_EMR |=> cmd_r == CMD_LMR && ba_r == BA_EXT;
  endproperty
  a_emr_mode: assert property (p_emr_mode) // [R3]
    else $error("extended load mode not issued");

  property p_aref_mode;
    @(posedge pclk) disable iff (!presetn)
      take && mode_r == MODE_AREF |=> cmd_r == CMD_AREF && cke_r;
  endproperty
  a_aref_mode: assert property (p_aref_mode) // [R4]
    else $error("auto-refresh mode wrong command");

  property p_dpd_mode;
    @(posedge pclk) disable iff (!presetn)
      take && mode_r == MODE_DPD |=> cmd_r == CMD_BST && !cke_r && ack_r;
  endproperty
  a_dpd_mode: assert property (p_dpd_mode) // [R5]
    else $error("deep power-down not entered");

  property p_no_ref_unwritten;
    @(posedge pclk) disable iff (!presetn)
      !ref_written_r |-> !ref_pend_r && cmd_r != CMD_AREF ||
                         mode_r == MODE_AREF || !cke_r;
  endproperty
  a_no_ref_unwritten: assert property (p_no_ref_unwritten) // [R7]
    else $error("refresh before count written");

  property p_lp_off;
    @(posedge pclk) disable iff (!presetn)
      st_r == ST_IDLE && lp_sel == LP_OFF && !acc_req |=>
        st_r != ST_LP && st_r != ST_DPD;
  endproperty
  a_lp_off: assert property (p_lp_off) // [R18]
    else $error("low power entered while inhibited");

  property p_ref_err;
    @(posedge pclk) disable iff (!presetn)
      ref_tick && ref_pend_r |=> rerr_r;
  endproperty
  a_ref_err: assert property (p_ref_err) // [R24]
    else $error("missed refresh not flagged");

  property p_sref_clk;
    @(posedge pclk) disable iff (!presetn)
      st_r == ST_LP && sref_r |-> !clk_out_r && !cke_r;
  endproperty
  a_sref_clk: assert property (p_sref_clk) // [R19]
    else $error("clock runs in self-refresh");

  c_normal: cover property (@(posedge pclk) take && mode_r == 3'h0
                            ##[1:200] ack_r);
  c_lmr: cover property (@(posedge pclk) take && mode_r == MODE_LMR);
  c_sref: cover property (@(posedge pclk) st_r == ST_LP && sref_r);
  c_rerr: cover property (@(posedge pclk) $rose(rerr_r));
endmodule : sdc_ctrl

// file: logic/sdc_pkg.sv
/*
 Constants, types and helpers of the SDRAM controller configuration block.
 Assumes an APB slave with byte addresses and 32-bit data.
*/
// Function
// [R1] Mode 0 normal, 1 NOP, 2 precharge all
// [R2] Mode 3: load mode with address offset
// [R3] Mode 5: extended load mode with offset
// [R4] Mode 4: auto-refresh; precharge all first; code issues the auto-refresh with no precharge before it
// [R5] Mode 6 enters deep power-down
// [R6] Refresh count reloads timer, pulse starts refresh
// [R7] No refresh before refresh count written
// [R8] Column 8-11 bits, row 11-13 bits
// [R9] Bank count bit: two or four banks
// [R10] CAS latency one to three, reset two
// [R11] Bus width bit: 0 wide, 1 narrow
// [R12] Write recovery 0-15 cycles, reset two
// [R13] Refresh to activate spacing, reset seven
// [R14] Precharge to next command, reset three
// [R15] Activate to read/write, reset two
// [R16] Activate to precharge, reset five
// [R17] Clock enable high to activate, reset eight
// [R18] Low-power select 00: no low-power commands
// [R19] Select 01: self-refresh, clock stopped, exit on access
// [R20] Select 10: power-down after each access
// [R21] Select 11: deep power-down command
// [R22] Partial array, temperature, drive fields held
// [R23] Timeout delays entry 0, 64, 128 cycles
// [R24] Missed refresh raises error, read clears it
// [R25] Forced modes apply always; code 7 normal
package sdc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CMD_MODE = 8'h00;
  localparam logic [7:0] OFS_REF_INT  = 8'h04;
  localparam logic [7:0] OFS_GEOM     = 8'h08;
  localparam logic [7:0] OFS_LOW_PWR  = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h20;
  // Reset values and writable bits
  localparam logic [31:0] RST_GEOM = 32'h852372c0;
  localparam logic [31:0] MSK_MODE = 32'h00000007;
  localparam logic [31:0] MSK_REF  = 32'h00000fff;
  localparam logic [31:0] MSK_LPR  = 32'h00003f73;
  // Field positions in the geometry/timing word
  localparam int FLD_NC = 0;
  localparam int FLD_NR = 2;
  localparam int FLD_NB = 4;
  localparam int FLD_CAS = 5;
  localparam int FLD_DBW = 7;
  localparam int FLD_TWR = 8;
  localparam int FLD_TRC = 12;
  localparam int FLD_TRP = 16;
  localparam int FLD_ROW_TO_COLUMN_CYCLES = 20;
  localparam int FLD_ACTIVE_TO_PRECHARGE_CYCLES = 24;
  localparam int FLD_SELF_REFRESH_EXIT_CYCLES = 28;
  // Field positions in the low-power word
  localparam int FLD_LOW_POWER_SELECT = 0;
  localparam int FLD_TMO = 12;
  // Command modes
  localparam logic [2:0] MODE_NOP  = 3'h1;
  localparam logic [2:0] MODE_PALL = 3'h2;
  localparam logic [2:0] MODE_LMR  = 3'h3;
  localparam logic [2:0] MODE_AREF = 3'h4;
  localparam logic [2:0] MODE_EMR  = 3'h5;
  localparam logic [2:0] MODE_DPD  = 3'h6;
  // Low-power selections and timeouts
  localparam logic [1:0] LP_OFF  = 2'h0;
  localparam logic [1:0] LP_SREF = 2'h1;
  localparam logic [1:0] LP_PDN  = 2'h2;
  localparam logic [1:0] LP_DEEP = 2'h3;
  localparam logic [7:0] TMO_64  = 8'h40;
  localparam logic [7:0] TMO_128 = 8'h80;
  // Memory commands {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP  = 4'h7;
  localparam logic [3:0] CMD_ACT  = 4'h3;
  localparam logic [3:0] CMD_RD   = 4'h5;
  localparam logic [3:0] CMD_WR   = 4'h4;
  localparam logic [3:0] CMD_PRE  = 4'h2;
  localparam logic [3:0] CMD_AREF = 4'h1;
  localparam logic [3:0] CMD_LMR  = 4'h0;
  localparam logic [3:0] CMD_BST  = 4'h6;
  localparam logic [1:0] BA_EXT   = 2'h2;
  localparam int         A_ALL    = 10;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ACT_WAIT, ST_POST, ST_PRE_WAIT, ST_REF_WAIT,
    ST_LP, ST_EXIT_WAIT, ST_DPD, ST_ACK
  } sdc_state_t;

  typedef struct packed {
    logic [1:0]  ba;
    logic [12:0] row;
    logic [12:0] col;
  } sdc_loc_t;

  // Split an address offset into bank, row and column
  function automatic sdc_loc_t sdc_split(input logic [31:0] off,
                                         input logic [31:0] cfg);
    logic [31:0] word;
    int          nc;
    int          nbk;
    sdc_loc_t    loc;
    word = cfg[FLD_DBW] ? (off >> 1) : (off >> 2); // [R11]
    nc   = 8 + int'(cfg[FLD_NC +: 2]); // [R8]
    nbk  = cfg[FLD_NB] ? 2 : 1; // [R9]
    loc.col = 13'(word & ((32'h1 << nc) - 32'h1));
    loc.ba  = 2'((word >> nc) & ((32'h1 << nbk) - 32'h1));
    loc.row = 13'((word >> (nc + nbk)) &
                  ((32'h1 << (11 + int'(cfg[FLD_NR +: 2]))) - 32'h1));
    return loc;
  endfunction : sdc_split
endpackage : sdc_pkg

// file: logic/sdc_ref_timer.sv
/*
 Refresh interval timer: reloads from the refresh count and pulses.
 Assumes load is a one-cycle pulse on each write of the count.
*/
`timescale 1ns/1ps
module sdc_ref_timer
  import sdc_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Count and load
  input  wire logic        load,
  input  wire logic [11:0] count,
  // Refresh pulse
  output logic             tick_r
);
  logic [11:0] cnt_r;
  logic        armed_r;

  // Armed only once software has written the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_r <= 1'b0;
    end else if (load) begin
      armed_r <= 1'b1; // [R7]
    end
  end

  // Down counter, reload on expiry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r  <= 12'h000;
      tick_r <= 1'b0;
    end else begin
      tick_r <= 1'b0;
      if (load) begin
        cnt_r <= count; // [R6]
      end else if (armed_r && count != 12'h000) begin
        if (cnt_r == 12'h000) begin
          cnt_r  <= count; // [R6]
          tick_r <= 1'b1;  // [R6]
        end else begin
          cnt_r <= cnt_r - 12'h001;
        end
      end
    end
  end

  property p_no_tick_unarmed;
    @(posedge pclk) disable iff (!presetn) !armed_r |-> ##1 !tick_r;
  endproperty
  a_no_tick_unarmed: assert property (p_no_tick_unarmed) // [R7]
    else $error("refresh pulse before count written");
endmodule : sdc_ref_timer

// file: verification/sdc_ctrl_test.sv
/*
 Self-checking bench of the SDRAM controller configuration block.
 Assumes APB answers in one access cycle and a behavioural memory.
*/
`timescale 1ns/1ps
module sdc_ctrl_test;
  import sdc_pkg::*;
  localparam logic [31:0] BASE = 32'h20000000;
  // Bench drive
  logic        pclk     = 1'b0;
  logic        presetn  = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic        acc_req  = 1'b0;
  logic        acc_wr   = 1'b0;
  logic [31:0] acc_addr = BASE;
  // Design outputs and model view
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        acc_ack;
  logic [3:0]  cmd;
  logic [12:0] maddr;
  logic [1:0]  mba;
  logic        cke;
  logic        mclk;
  logic [3:0]  last_cmd;
  logic [12:0] last_addr;
  logic [1:0]  last_ba;
  int          cmd_cnt;
  int          aref_cnt;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          c0;
  logic [31:0] rd;
  logic        err;
  logic [2:0]  modes [5]   = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h5};
  logic [3:0]  exp_cmd [5] = '{CMD_NOP, CMD_PRE, CMD_AREF, CMD_LMR, CMD_LMR};
  logic [31:0] offs [5]    = '{32'h0, 32'h0, 32'h0, 32'h6032, 32'h0021};
  logic [1:0]  exp_ba [5]  = '{2'h0, 2'h0, 2'h0, 2'h3, BA_EXT};

  always #2 pclk = ~pclk;

  sdc_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .acc_req(acc_req), .acc_wr(acc_wr), .acc_addr(acc_addr),
    .acc_ack(acc_ack), .mem_cs_n(cmd[3]), .mem_ras_n(cmd[2]),
    .mem_cas_n(cmd[1]), .mem_we_n(cmd[0]), .mem_addr(maddr),
    .mem_ba(mba), .memory_clock_enable(cke), .memory_clock_out(mclk));

  sdc_mem_model mem (.clk(mclk), .cke(cke), .cmd(cmd), .addr(maddr),
    .ba(mba), .last_cmd(last_cmd), .last_addr(last_addr),
    .last_ba(last_ba), .cmd_cnt(cmd_cnt), .aref_cnt(aref_cnt));

  // Compare and count
  task chk(input string what, input logic [31:0] seen,
           input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One APB transfer, held until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) error_cnt++;
  endtask : apb

  // One memory access, held until acknowledge
  task acc(input logic w, input logic [31:0] a);
    int n;
    @(posedge pclk);
    acc_req  <= 1'b1;
    acc_wr   <= w;
    acc_addr <= a;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (acc_ack !== 1'b1 && n < 3000);
    acc_req <= 1'b0;
    if (n >= 3000) error_cnt++;
  endtask : acc

  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task final_report;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  // Hang guard, well beyond the expected run
  initial begin
    #100000;
    error_cnt++;
    final_report();
  end

  initial begin
    cyc(4);
    presetn <= 1'b1;
    apb(1'b0, OFS_CMD_MODE, 32'h0);
    chk("mode", rd, 32'h0);
    apb(1'b0, OFS_REF_INT, 32'h0);
    chk("count", rd, 32'h0);
    apb(1'b0, OFS_GEOM, 32'h0);
    chk("config", rd, RST_GEOM);
    apb(1'b1, OFS_GEOM, 32'hfffffff7);
    apb(1'b0, OFS_GEOM, 32'h0);
    chk("config rw", rd, 32'hfffffff7);
    apb(1'b1, OFS_GEOM, RST_GEOM);
    apb(1'b1, OFS_LOW_PWR, 32'hfffffff0);
    apb(1'b0, OFS_LOW_PWR, 32'h0);
    chk("low power", rd, 32'h3f70);
    apb(1'b1, OFS_LOW_PWR, 32'h0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status", rd, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped err", 32'(err), 32'h1);
    $display("registers done");
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, OFS_CMD_MODE, 32'(modes[i]));
      c0 = cmd_cnt;
      acc(1'b0, BASE + offs[i]);
      cyc(4);
      chk("cmd count", 32'(cmd_cnt - c0), 32'(i != 0));
      chk("cmd", 32'(last_cmd), 32'(exp_cmd[i]));
      if (i == 1) chk("a10", 32'(last_addr[A_ALL]), 32'h1);
      if (i > 2) begin
        chk("mode addr", 32'(last_addr), offs[i] & 32'h1fff);
        chk("mode bank", 32'(last_ba), 32'(exp_ba[i]));
      end
    end
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, OFS_CMD_MODE, (i == 1) ? 32'h7 : 32'h0);
      c0 = cmd_cnt;
      acc(i == 1, BASE + 32'h100);
      cyc(4);
      chk("normal count", 32'(cmd_cnt - c0), 32'h3);
      chk("normal last", 32'(last_cmd), 32'(CMD_PRE));
    end
    $display("command modes done");
    c0 = aref_cnt;
    apb(1'b1, OFS_LOW_PWR, 32'h1002);
    acc(1'b0, BASE);
    cyc(58);
    chk("cke hold", 32'(cke), 32'h1);
    cyc(12);
    chk("cke down", 32'(cke), 32'h0);
    apb(1'b1, OFS_LOW_PWR, 32'h1);
    acc(1'b0, BASE);
    cyc(20);
    chk("sref cke", 32'(cke), 32'h0);
    chk("sref clock", 32'(mclk), 32'h0);
    apb(1'b1, OFS_LOW_PWR, 32'h0);
    acc(1'b0, BASE);
    cyc(150);
    chk("lp off cke", 32'(cke), 32'h1);
    chk("no refresh", 32'(aref_cnt - c0), 32'h0);
    $display("low power done");
    apb(1'b1, OFS_REF_INT, 32'h40);
    c0 = aref_cnt;
    cyc(400);
    chk("refreshes", 32'(aref_cnt - c0 >= 5 && aref_cnt - c0 <= 7), 32'h1);
    $display("refresh done");
    apb(1'b1, OFS_CMD_MODE, 32'(MODE_DPD));
    acc(1'b0, BASE);
    cyc(10);
    chk("deep cke", 32'(cke), 32'h0);
    $display("deep power-down done");
    final_report();
  end
endmodule : sdc_ctrl_test

// file: verification/sdc_mem_model.sv
/*
 Behavioural SDRAM device: decodes each command on its rising clock.
 Assumes commands stand still around every rising memory clock.
*/
`timescale 1ns/1ps
module sdc_mem_model
  import sdc_pkg::*;
(
  // Command pins
  input  wire logic        clk,
  input  wire logic        cke,
  input  wire logic [3:0]  cmd,
  input  wire logic [12:0] addr,
  input  wire logic [1:0]  ba,
  // Observed state
  output logic [3:0]       last_cmd,
  output logic [12:0]      last_addr,
  output logic [1:0]       last_ba,
  output int               cmd_cnt,
  output int               aref_cnt
);
  // Nothing seen yet
  initial begin
    last_cmd  = CMD_NOP;
    last_addr = 13'h0000;
    last_ba   = 2'h0;
    cmd_cnt   = 0;
    aref_cnt  = 0;
  end

  // Latch every command other than NOP clocked while cke is high
  always @(posedge clk) begin
    if (cke === 1'b1 && cmd !== CMD_NOP) begin
      last_cmd  <= cmd;
      last_addr <= addr;
      last_ba   <= ba;
      cmd_cnt   <= cmd_cnt + 1;
      if (cmd === CMD_AREF) begin
        aref_cnt <= aref_cnt + 1;
      end
    end
  end
endmodule : sdc_mem_model
